//--- hw/dhbp_pkg.sv
// Purpose: Shared constants and types for the dual channel host bus port
// Assumes: All host pins are synchronous to ref_clk_in
// Notes: Behaviour list below; the logic is in dhbp_port.sv
//
// Behaviour
// - Three register-select bits pick one register of the addressed channel.
// - Eight-bit data bus is driven only during reads, input otherwise.
// - Strobe mode: read strobe fall reads register; host captures on rise.
// - Strobe mode: write strobe fall starts write; data stored on rise.
// - Direction-line mode: separate read strobe is ignored.
// - Direction-line mode: direction high reads, low writes.
// - Strobe mode: each channel answers only under its own select.
// - Direction-line mode: access taken only while single select is low.
// - Direction-line mode: channel B select becomes channel pick bit.
// - Strobe mode: channel A irq active high, enabled by its control bit.
// - Strobe mode: channel B irq likewise, enabled by its control bit.
// - Direction-line mode: channel A pin is shared active-low open-drain irq.
// - Direction-line mode: channel B irq pin stays unused.
// - After power-up the device is fully active.
// - Asleep with isolation requested, all host bus cycles are ignored.
// - Full sleep stops oscillator and pump; partial sleep stops one.
// - Returning to active from any low-power mode raises a wake-up interrupt.

package dhbp_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int EDGE_W = 4;

  // Edge detector lane positions
  localparam int LANE_RD = 0;
  localparam int LANE_WR = 1;
  localparam int LANE_CSA = 2;
  localparam int LANE_CSB = 3;

  // Bus style select levels
  localparam logic STYLE_STROBE = 1'b1;
  localparam logic STYLE_DIRLINE = 1'b0;

  // Channel codes
  localparam logic CHAN_A = 1'b0;
  localparam logic CHAN_B = 1'b1;

  // Reset values
  localparam logic [EDGE_W-1:0] EDGE_IDLE_RST = 4'hF;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;

  // Access sequencer, Gray along idle-read/idle-write
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } dhbp_acc_t;

  // Power modes, Gray around the ring
  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_OSC_OFF = 2'b01,
    PM_FULL = 2'b11,
    PM_PUMP_OFF = 2'b10
  } dhbp_pm_t;

endpackage

//--- hw/dhbp_edge_det.sv
// Purpose: Edge detector for the host strobes and selects
// Assumes: Inputs already synchronous to ref_clk_in
// Notes: Idles high so no false edge right after reset
`timescale 1ns/1ps

module dhbp_edge_det (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Sampled levels
  input wire logic [dhbp_pkg::EDGE_W-1:0] level_in,
  // Edge pulses
  output logic [dhbp_pkg::EDGE_W-1:0] fall_out,
  output logic [dhbp_pkg::EDGE_W-1:0] rise_out
);

  logic [dhbp_pkg::EDGE_W-1:0] prev_reg;
  logic [dhbp_pkg::EDGE_W-1:0] prev_next;

  always_comb begin
    prev_next = level_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      prev_reg <= dhbp_pkg::EDGE_IDLE_RST;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign fall_out = prev_reg & ~level_in;
  assign rise_out = ~prev_reg & level_in;

endmodule

//--- hw/dhbp_port.sv
// Purpose: Host bus port of a two channel UART, both bus styles
// Assumes: Host pins synchronous to ref_clk_in; channel cores answer reads at once
// Notes: Data pins come as in/out/enable; irq pins as out/enable
`timescale 1ns/1ps

module dhbp_port (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // Static configuration
  input wire logic bus_style_in,
  // Host bus pins
  input wire logic reg_sel_bit2_in,
  input wire logic reg_sel_bit1_in,
  input wire logic reg_sel_bit0_in,
  input wire logic read_strobe_n_in,
  input wire logic write_strobe_n_in,
  input wire logic chan_a_select_n_in,
  input wire logic chan_b_select_n_in,
  input wire logic [dhbp_pkg::DATA_W-1:0] data_in,
  output logic [dhbp_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  // Interrupt pins
  output logic chan_a_irq_out,
  output logic chan_a_irq_oe_out,
  output logic chan_b_irq_out,
  output logic chan_b_irq_oe_out,
  // Power control
  input wire logic bus_isolate_req_in,
  input wire logic osc_sleep_req_in,
  input wire logic pump_sleep_req_in,
  input wire logic wake_ack_in,
  output logic osc_stop_out,
  output logic pump_stop_out,
  output logic wake_irq_out,
  // Channel core side
  input wire logic [dhbp_pkg::DATA_W-1:0] chan_a_rd_data_in,
  input wire logic [dhbp_pkg::DATA_W-1:0] chan_b_rd_data_in,
  input wire logic chan_a_irq_req_in,
  input wire logic chan_b_irq_req_in,
  input wire logic chan_a_irq_en_in,
  input wire logic chan_b_irq_en_in,
  output logic core_rd_pulse_out,
  output logic core_wr_pulse_out,
  output logic core_chan_out,
  output logic [dhbp_pkg::ADDR_W-1:0] core_addr_out,
  output logic [dhbp_pkg::DATA_W-1:0] core_wr_data_out
);

  logic [dhbp_pkg::EDGE_W-1:0] fall;
  logic [dhbp_pkg::EDGE_W-1:0] rise;
  logic strobe_mode;
  logic isolate;
  logic any_cs_n;
  logic start_rd;
  logic start_wr;
  logic end_acc;
  logic start_chan;

  dhbp_pkg::dhbp_acc_t acc_reg;
  dhbp_pkg::dhbp_acc_t acc_next;
  logic chan_reg;
  logic chan_next;
  logic [dhbp_pkg::ADDR_W-1:0] addr_reg;
  logic [dhbp_pkg::ADDR_W-1:0] addr_next;
  logic [dhbp_pkg::DATA_W-1:0] rd_data_reg;
  logic [dhbp_pkg::DATA_W-1:0] rd_data_next;
  logic [dhbp_pkg::DATA_W-1:0] wr_data_reg;
  logic [dhbp_pkg::DATA_W-1:0] wr_data_next;

  dhbp_pkg::dhbp_pm_t pm_reg;
  dhbp_pkg::dhbp_pm_t pm_next;
  logic wake_reg;
  logic wake_next;

  // Picks the read byte of one channel
  function automatic logic [dhbp_pkg::DATA_W-1:0] chan_mux(
    input logic chan,
    input logic [dhbp_pkg::DATA_W-1:0] a,
    input logic [dhbp_pkg::DATA_W-1:0] b
  );
    chan_mux = (chan == dhbp_pkg::CHAN_B) ? b : a;
  endfunction

  dhbp_edge_det u_edge (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .level_in({chan_b_select_n_in, chan_a_select_n_in, write_strobe_n_in, read_strobe_n_in}),
    .fall_out(fall),
    .rise_out(rise)
  );

  // Style treated as static, read directly each cycle
  assign strobe_mode = (bus_style_in == dhbp_pkg::STYLE_STROBE);
  assign isolate = bus_isolate_req_in && (pm_reg != dhbp_pkg::PM_ACTIVE);
  assign any_cs_n = chan_a_select_n_in & chan_b_select_n_in;

  // Access start and end conditions per bus style
  always_comb begin
    if (strobe_mode) begin
      start_rd = fall[dhbp_pkg::LANE_RD] && !any_cs_n;
      start_wr = fall[dhbp_pkg::LANE_WR] && !any_cs_n;
      // Channel A wins if the host lowers both selects
      start_chan = chan_a_select_n_in ? dhbp_pkg::CHAN_B : dhbp_pkg::CHAN_A;
      end_acc = (acc_reg == dhbp_pkg::ACC_READ) ? rise[dhbp_pkg::LANE_RD]
                                                 : rise[dhbp_pkg::LANE_WR];
    end else begin
      // Read strobe lane not consulted here
      start_rd = fall[dhbp_pkg::LANE_CSA] && write_strobe_n_in;
      start_wr = fall[dhbp_pkg::LANE_CSA] && !write_strobe_n_in;
      start_chan = chan_b_select_n_in;
      end_acc = rise[dhbp_pkg::LANE_CSA];
    end
  end

  // Access sequencer
  always_comb begin
    acc_next = acc_reg;
    chan_next = chan_reg;
    addr_next = addr_reg;
    rd_data_next = rd_data_reg;
    wr_data_next = wr_data_reg;
    core_rd_pulse_out = 1'b0;
    core_wr_pulse_out = 1'b0;
    if (isolate) begin
      acc_next = dhbp_pkg::ACC_IDLE;
    end else begin
      case (acc_reg)
        dhbp_pkg::ACC_IDLE: begin
          if (start_rd) begin
            acc_next = dhbp_pkg::ACC_READ;
            chan_next = start_chan;
            addr_next = {reg_sel_bit2_in, reg_sel_bit1_in, reg_sel_bit0_in};
            core_rd_pulse_out = 1'b1;
          end else if (start_wr) begin
            acc_next = dhbp_pkg::ACC_WRITE;
            chan_next = start_chan;
            addr_next = {reg_sel_bit2_in, reg_sel_bit1_in, reg_sel_bit0_in};
          end
        end
        dhbp_pkg::ACC_READ: begin
          rd_data_next = chan_mux(chan_reg, chan_a_rd_data_in, chan_b_rd_data_in);
          if (end_acc) begin
            acc_next = dhbp_pkg::ACC_IDLE;
          end
        end
        dhbp_pkg::ACC_WRITE: begin
          if (end_acc) begin
            acc_next = dhbp_pkg::ACC_IDLE;
            core_wr_pulse_out = 1'b1;
          end else begin
            // Host holds data until the closing edge
            wr_data_next = data_in;
          end
        end
        default: begin
          acc_next = dhbp_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      acc_reg <= dhbp_pkg::ACC_IDLE;
      chan_reg <= dhbp_pkg::CHAN_A;
      addr_reg <= dhbp_pkg::ADDR_RST;
      rd_data_reg <= dhbp_pkg::DATA_RST;
      wr_data_reg <= dhbp_pkg::DATA_RST;
    end else begin
      acc_reg <= acc_next;
      chan_reg <= chan_next;
      addr_reg <= addr_next;
      rd_data_reg <= rd_data_next;
      wr_data_reg <= wr_data_next;
    end
  end

  // Data bus drives only through a read
  assign data_out = rd_data_reg;
  assign data_oe_out = (acc_reg == dhbp_pkg::ACC_READ) && !isolate;
  assign core_chan_out = chan_reg;
  assign core_addr_out = addr_reg;
  assign core_wr_data_out = wr_data_reg;

  // Power mode follows the sleep requests
  always_comb begin
    case ({osc_sleep_req_in, pump_sleep_req_in})
      2'b11: pm_next = dhbp_pkg::PM_FULL;
      2'b10: pm_next = dhbp_pkg::PM_OSC_OFF;
      2'b01: pm_next = dhbp_pkg::PM_PUMP_OFF;
      default: pm_next = dhbp_pkg::PM_ACTIVE;
    endcase
    // Set beats acknowledge so no wake-up is lost
    wake_next = wake_reg && !wake_ack_in;
    if (pm_reg != dhbp_pkg::PM_ACTIVE && pm_next == dhbp_pkg::PM_ACTIVE) begin
      wake_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      pm_reg <= dhbp_pkg::PM_ACTIVE;
      wake_reg <= 1'b0;
    end else begin
      pm_reg <= pm_next;
      wake_reg <= wake_next;
    end
  end

  assign osc_stop_out = pm_reg[0];
  assign pump_stop_out = pm_reg[1] ^ pm_reg[0] ? pm_reg[1] : pm_reg[1];
  assign wake_irq_out = wake_reg;

  // Interrupt pins; wake-up is folded into both channels
  always_comb begin
    if (strobe_mode) begin
      chan_a_irq_out = chan_a_irq_req_in || wake_reg;
      chan_a_irq_oe_out = chan_a_irq_en_in;
      chan_b_irq_out = chan_b_irq_req_in || wake_reg;
      chan_b_irq_oe_out = chan_b_irq_en_in;
    end else begin
      // Open drain: only ever pulls low, enable-bit expected low
      chan_a_irq_out = 1'b0;
      chan_a_irq_oe_out = chan_a_irq_req_in || chan_b_irq_req_in || wake_reg;
      chan_b_irq_out = 1'b0;
      chan_b_irq_oe_out = 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  a_read_start: assert property (
    (strobe_mode && acc_reg == dhbp_pkg::ACC_IDLE && fall[dhbp_pkg::LANE_RD] && !any_cs_n
      && !isolate && !$changed(bus_style_in)) |-> core_rd_pulse_out ##1 data_oe_out)
    else $error("read strobe fall did not start a read");
  a_write_commit: assert property (
    (strobe_mode && acc_reg == dhbp_pkg::ACC_WRITE && rise[dhbp_pkg::LANE_WR] && !isolate)
      |-> core_wr_pulse_out ##1 (acc_reg == dhbp_pkg::ACC_IDLE))
    else $error("write strobe rise did not commit");
  a_data_drive: assert property (
    data_oe_out |-> (acc_reg == dhbp_pkg::ACC_READ) && $past(acc_reg) != dhbp_pkg::ACC_WRITE)
    else $error("data bus driven outside a read");
  a_dir_read: assert property (
    (!strobe_mode && core_rd_pulse_out) |-> fall[dhbp_pkg::LANE_CSA] && write_strobe_n_in)
    else $error("direction mode read without select fall and read level");
  a_strobe_sel: assert property (
    (strobe_mode && (core_rd_pulse_out || start_wr && acc_reg == dhbp_pkg::ACC_IDLE
      && !isolate)) |=> (core_chan_out == $past(chan_a_select_n_in)))
    else $error("strobe mode channel not from its select");
  a_chan_pick: assert property (
    (!strobe_mode && acc_reg == dhbp_pkg::ACC_IDLE && fall[dhbp_pkg::LANE_CSA] && !isolate)
      |=> core_chan_out == $past(chan_b_select_n_in))
    else $error("channel pick bit not honoured");
  a_irq_a_en: assert property (
    strobe_mode |-> chan_a_irq_oe_out == chan_a_irq_en_in
      && chan_a_irq_out == (chan_a_irq_req_in || wake_irq_out))
    else $error("channel A irq enable wrong");
  a_irq_b_en: assert property (
    strobe_mode |-> chan_b_irq_oe_out == chan_b_irq_en_in)
    else $error("channel B irq enable wrong");
  a_irq_shared: assert property (
    !strobe_mode |-> !chan_a_irq_out && chan_a_irq_oe_out ==
      (chan_a_irq_req_in || chan_b_irq_req_in || wake_irq_out))
    else $error("shared irq wrong");
  a_irq_b_idle: assert property (
    !strobe_mode |-> !chan_b_irq_oe_out)
    else $error("channel B irq driven in direction mode");
  a_power_up: assert property (
    $rose(resetn_in) |-> pm_reg == dhbp_pkg::PM_ACTIVE && !osc_stop_out && !pump_stop_out)
    else $error("not active after reset");
  a_isolated: assert property (
    isolate |-> !core_rd_pulse_out && !core_wr_pulse_out && !data_oe_out
      ##1 acc_reg == dhbp_pkg::ACC_IDLE)
    else $error("bus cycle taken while isolated");
  a_full_sleep: assert property (
    (osc_sleep_req_in && pump_sleep_req_in) |=> osc_stop_out && pump_stop_out)
    else $error("full sleep left a source running");
  a_wake_raise: assert property (
    (pm_reg != dhbp_pkg::PM_ACTIVE && !osc_sleep_req_in && !pump_sleep_req_in)
      |=> wake_irq_out ##1 (wake_irq_out || $past(wake_ack_in)))
    else $error("wake-up interrupt missing");
  a_addr_latch: assert property (
    (core_rd_pulse_out || start_wr && acc_reg == dhbp_pkg::ACC_IDLE && !isolate)
      |=> core_addr_out == {$past(reg_sel_bit2_in), $past(reg_sel_bit1_in),
        $past(reg_sel_bit0_in)})
    else $error("register select not latched");
  a_dir_write: assert property (
    (!strobe_mode && acc_reg == dhbp_pkg::ACC_IDLE && fall[dhbp_pkg::LANE_CSA] && !isolate
      && !write_strobe_n_in) |=> acc_reg == dhbp_pkg::ACC_WRITE)
    else $error("direction mode write not started");
  a_dir_commit: assert property (
    (!strobe_mode && acc_reg == dhbp_pkg::ACC_WRITE && rise[dhbp_pkg::LANE_CSA] && !isolate)
      |-> core_wr_pulse_out)
    else $error("select rise did not commit the write");
  a_pump_only: assert property (
    (!osc_sleep_req_in && pump_sleep_req_in) |=> !osc_stop_out && pump_stop_out)
    else $error("pump-only sleep wrong");

  c_strobe_read: cover property (strobe_mode && core_rd_pulse_out ##[1:20] !data_oe_out);
  c_strobe_write: cover property (strobe_mode && core_wr_pulse_out);
  c_dir_write: cover property (!strobe_mode && core_wr_pulse_out && core_chan_out);
  c_wake: cover property ($rose(wake_irq_out));

endmodule

//--- tb/dhbp_host_model.sv
// Purpose: Host processor model for the dual channel host bus port
// Assumes: One access at a time; host strobes and selects idle high between accesses
// Notes: Released data lines toggle each cycle so a stale byte never matches
`timescale 1ns/1ps

module dhbp_host_model (
  // Clock
  input wire logic ref_clk_in,
  // Device data pins
  input wire logic [7:0] dev_data_in,
  input wire logic dev_oe_in,
  // Host pins
  output logic [2:0] addr_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic cs_a_n_out,
  output logic cs_b_n_out,
  output logic [7:0] bus_out,
  // Read capture
  output logic rd_valid_out,
  output logic rd_drove_out,
  output logic [7:0] rd_byte_out
);
  logic host_oe = 1'b0;
  logic [7:0] host_d = 8'h00;
  logic [7:0] idle_pat = 8'h5A;

  always @(posedge ref_clk_in) begin
    idle_pat <= ~idle_pat;
  end

  // No pull on these lines, so nobody driving means a changing pattern
  assign bus_out = dev_oe_in ? dev_data_in : (host_oe ? host_d : idle_pat);

  initial begin
    {addr_out, rd_valid_out, rd_drove_out, rd_byte_out} = '0;
    {rd_n_out, wr_n_out, cs_a_n_out, cs_b_n_out} = 4'hF;
  end

  // Dir selects direction-line style; sel asserts the select
  task automatic xfer(input logic dir, chan, rd, sel, input logic [2:0] a,
                      input logic [7:0] d);
    logic drove;
    drove = 1'b0;
    @(posedge ref_clk_in);
    addr_out <= a;
    host_oe <= ~rd;
    host_d <= d;
    wr_n_out <= rd;
    if (dir) begin
      cs_a_n_out <= ~sel;
      cs_b_n_out <= chan;
      rd_n_out <= 1'b0; // Stray read strobe must be ignored
    end else begin
      cs_a_n_out <= ~(sel & ~chan);
      cs_b_n_out <= ~(sel & chan);
      rd_n_out <= ~rd;
    end
    repeat (5) begin
      @(negedge ref_clk_in);
      drove = drove | dev_oe_in;
    end
    rd_byte_out <= bus_out;
    @(posedge ref_clk_in);
    {rd_n_out, wr_n_out, cs_a_n_out, cs_b_n_out} <= 4'hF;
    rd_valid_out <= rd;
    rd_drove_out <= drove;
    @(posedge ref_clk_in);
    rd_valid_out <= 1'b0;
    host_oe <= 1'b0; // Data held one edge past the strobe rise
    repeat (2) @(posedge ref_clk_in);
  endtask
endmodule

//--- tb/dual_channel_host_bus_port_tb.sv
// Purpose: Self-checking bench for the dual channel host bus port
// Assumes: Host model drives the bus; register arrays stand in for both cores
// Notes: Expected results queue in access order; monitor pops one per result
`timescale 1ns/1ps

module dual_channel_host_bus_port_tb;
  logic ref_clk_in, resetn_in, bus_style_in;
  logic rd_n, wr_n, cs_a_n, cs_b_n, data_oe_out, rd_valid, rd_drove;
  logic [2:0] sel_addr, core_addr_out;
  logic [7:0] data_bus, data_out, rd_byte, core_wr_data_out;
  logic [7:0] chan_a_rd_data_in, chan_b_rd_data_in;
  logic chan_a_irq_out, chan_a_irq_oe_out, chan_b_irq_out, chan_b_irq_oe_out;
  logic bus_isolate_req_in, osc_sleep_req_in, pump_sleep_req_in, wake_ack_in;
  logic osc_stop_out, pump_stop_out, wake_irq_out;
  logic chan_a_irq_req_in, chan_b_irq_req_in, chan_a_irq_en_in, chan_b_irq_en_in;
  logic core_rd_pulse_out, core_wr_pulse_out, core_chan_out;
  logic [7:0] core_a [8];
  logic [7:0] core_b [8];
  logic [7:0] sh_a [8];
  logic [7:0] sh_b [8];
  logic [13:0] exp_q [$];
  logic [13:0] e;
  logic [31:0] rnd;
  integer seed, n_mismatch, n_checks, m, c, i;

  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  dhbp_port DUT (
    .ref_clk_in, .resetn_in, .bus_style_in,
    .reg_sel_bit2_in(sel_addr[2]), .reg_sel_bit1_in(sel_addr[1]),
    .reg_sel_bit0_in(sel_addr[0]), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
    .chan_a_select_n_in(cs_a_n), .chan_b_select_n_in(cs_b_n),
    .data_in(data_bus), .data_out, .data_oe_out,
    .chan_a_irq_out, .chan_a_irq_oe_out, .chan_b_irq_out, .chan_b_irq_oe_out,
    .bus_isolate_req_in, .osc_sleep_req_in, .pump_sleep_req_in, .wake_ack_in,
    .osc_stop_out, .pump_stop_out, .wake_irq_out,
    .chan_a_rd_data_in, .chan_b_rd_data_in, .chan_a_irq_req_in, .chan_b_irq_req_in,
    .chan_a_irq_en_in, .chan_b_irq_en_in, .core_rd_pulse_out, .core_wr_pulse_out,
    .core_chan_out, .core_addr_out, .core_wr_data_out);

  dhbp_host_model HOST (
    .ref_clk_in, .dev_data_in(data_out), .dev_oe_in(data_oe_out),
    .addr_out(sel_addr), .rd_n_out(rd_n), .wr_n_out(wr_n), .cs_a_n_out(cs_a_n),
    .cs_b_n_out(cs_b_n), .bus_out(data_bus), .rd_valid_out(rd_valid),
    .rd_drove_out(rd_drove), .rd_byte_out(rd_byte));

  // Cores answer with the live value at the latched address
  assign chan_a_rd_data_in = core_a[core_addr_out];
  assign chan_b_rd_data_in = core_b[core_addr_out];
  always @(posedge ref_clk_in) begin
    if (core_wr_pulse_out === 1'b1 && core_chan_out) core_b[core_addr_out] <= core_wr_data_out;
    if (core_wr_pulse_out === 1'b1 && !core_chan_out) core_a[core_addr_out] <= core_wr_data_out;
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_res(input logic [13:0] got, input logic [13:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Note fields: read, taken, channel, address, data
  task automatic acc(input logic dir, chan, rd, sel, input logic [2:0] a,
                     input logic [7:0] d, input logic ok);
    if (rd) exp_q.push_back({1'b1, ok, chan, a, chan ? sh_b[a] : sh_a[a]});
    if (!rd && ok) exp_q.push_back({2'b01, chan, a, d});
    if (!rd && ok && chan) sh_b[a] = d;
    if (!rd && ok && !chan) sh_a[a] = d;
    HOST.xfer(dir, chan, rd, sel, a, d);
  endtask

  // Refused accesses note no write, so any stray commit lands on an empty queue
  always @(posedge ref_clk_in) begin
    if (core_wr_pulse_out === 1'b1 || rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk_bit(1'b0, 1'b1, "unexpected result");
      end else begin
        e = exp_q.pop_front();
        if (rd_valid === 1'b1)
          chk_res({1'b1, rd_drove, e[11:8], rd_drove ? rd_byte : e[7:0]}, e, "read");
        else
          chk_res({2'b01, core_chan_out, core_addr_out, core_wr_data_out}, e, "write");
      end
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk_in);
    n_mismatch++;
    results();
  end

  initial begin
    seed = 32'hA2907808;
    n_mismatch = 0;
    n_checks = 0;
    resetn_in = 1'b0;
    bus_style_in = dhbp_pkg::STYLE_STROBE;
    {bus_isolate_req_in, osc_sleep_req_in, pump_sleep_req_in, wake_ack_in} = 4'h0;
    {chan_a_irq_req_in, chan_b_irq_req_in, chan_a_irq_en_in, chan_b_irq_en_in} = 4'h0;
    for (i = 0; i < 8; i++) begin
      {core_a[i], core_b[i], sh_a[i], sh_b[i]} = 32'h0;
    end
    repeat (4) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    @(negedge ref_clk_in);
    chk_bit(osc_stop_out | pump_stop_out | wake_irq_out, 1'b0, "power-up");
    chk_bit(data_oe_out, 1'b0, "bus released");
    for (m = 0; m < 2; m++) begin
      @(posedge ref_clk_in);
      bus_style_in <= m[0] ? dhbp_pkg::STYLE_DIRLINE : dhbp_pkg::STYLE_STROBE;
      for (c = 0; c < 2; c++) for (i = 0; i < 8; i++) begin
        rnd = $random(seed);
        acc(m[0], c[0], 1'b0, 1'b1, i[2:0], rnd[7:0], 1'b1);
      end
      for (c = 0; c < 2; c++) for (i = 0; i < 8; i++) begin
        acc(m[0], c[0], 1'b1, 1'b1, i[2:0], 8'h00, 1'b1);
      end
      acc(m[0], 1'b1, 1'b0, 1'b0, 3'h5, 8'hC3, 1'b0);
      acc(m[0], 1'b1, 1'b1, 1'b0, 3'h5, 8'h00, 1'b0);
      $display("test bus style %0d done", m);
    end
    @(posedge ref_clk_in);
    bus_style_in <= dhbp_pkg::STYLE_STROBE;
    bus_isolate_req_in <= 1'b1;
    acc(1'b0, 1'b0, 1'b0, 1'b1, 3'h2, 8'hA5, 1'b1); // Awake, so still taken
    osc_sleep_req_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk_bit(osc_stop_out & ~pump_stop_out, 1'b1, "partial sleep");
    acc(1'b0, 1'b1, 1'b0, 1'b1, 3'h2, 8'h3C, 1'b0);
    acc(1'b0, 1'b1, 1'b1, 1'b1, 3'h2, 8'h00, 1'b0);
    pump_sleep_req_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk_bit(osc_stop_out & pump_stop_out, 1'b1, "full sleep");
    @(posedge ref_clk_in);
    osc_sleep_req_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk_bit(~osc_stop_out & pump_stop_out, 1'b1, "pump-only sleep");
    @(posedge ref_clk_in);
    {bus_isolate_req_in, osc_sleep_req_in, pump_sleep_req_in} <= 3'h0;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk_bit(wake_irq_out & ~osc_stop_out & ~pump_stop_out, 1'b1, "wake raised");
    @(posedge ref_clk_in);
    wake_ack_in <= 1'b1;
    @(posedge ref_clk_in);
    wake_ack_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk_bit(wake_irq_out, 1'b0, "wake cleared");
    acc(1'b0, 1'b1, 1'b1, 1'b1, 3'h2, 8'h00, 1'b1); // Isolated write left no trace
    $display("test power modes done");
    for (m = 0; m < 2; m++) for (i = 0; i < 16; i++) begin
      @(posedge ref_clk_in);
      bus_style_in <= m[0] ? dhbp_pkg::STYLE_DIRLINE : dhbp_pkg::STYLE_STROBE;
      {chan_a_irq_req_in, chan_b_irq_req_in} <= i[1:0];
      {chan_a_irq_en_in, chan_b_irq_en_in} <= m[0] ? 2'b00 : i[3:2];
      @(negedge ref_clk_in);
      if (m == 0) begin
        chk_bit(chan_a_irq_oe_out, i[3], "irq a enable");
        chk_bit(chan_b_irq_oe_out, i[2], "irq b enable");
        if (i[3]) chk_bit(chan_a_irq_out, i[1], "irq a level");
        if (i[2]) chk_bit(chan_b_irq_out, i[0], "irq b level");
      end else begin
        chk_bit(chan_a_irq_oe_out, i[1] | i[0], "shared irq drive");
        if (i[1] | i[0]) chk_bit(chan_a_irq_out, 1'b0, "shared irq low");
        chk_bit(chan_b_irq_oe_out, 1'b0, "irq b unused");
      end
    end
    $display("test interrupt pins done");
    chk_bit(exp_q.size() == 0, 1'b1, "results outstanding");
    results();
  end
endmodule
